// ---- src/adc_seq_pkg.sv ----
// constants and types shared by the conversion sequencer files
package adc_seq_pkg;
    // ************************************************************
    // bus map (word addresses on the Avalon-MM slave)
    // ************************************************************
    localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
    localparam logic [3:0] ADDR_MODE     = 4'h2;
    localparam logic [3:0] ADDR_RES_HIGH = 4'h3;
    localparam logic [3:0] ADDR_RES_LOW  = 4'h4;
    localparam logic [3:0] ADDR_ANALOG   = 4'h5;
    // control a fields
    localparam int BIT_START   = 7;
    localparam int BIT_BUSY    = 6;
    localparam int BIT_POWER   = 5;
    localparam int BIT_FORMAT  = 4;
    localparam int CHAN_LSB    = 0;
    // control b fields
    localparam int SRC_LSB     = 5;
    localparam int REF_LSB     = 3;
    localparam int DIV_LSB     = 0;
    // mode register fields
    localparam int BIT_ACCUM   = 0;
    localparam int BIT_IRQ_EN  = 1;
    localparam int BIT_GIE     = 2;
    localparam int BIT_IRQ_FLG = 3;
    localparam int BIT_PINSEL0 = 4;
    localparam int BIT_PINSEL1 = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ************************************************************
    // timing
    // ************************************************************
    localparam logic [4:0] SAMPLE_CYCLES = 5'h04;
    localparam logic [4:0] TOTAL_CYCLES  = 5'h10;
    localparam logic [4:0] ACCUM_COUNT   = 5'h10;
    localparam logic [1:0] REF_INTERNAL  = 2'h1;
    localparam logic [3:0] CHAN_ZERO     = 4'h0;
    localparam logic [3:0] CHAN_ONE      = 4'h1;
    typedef enum logic [2:0] {
        SRC_OFF, SRC_EXT0, SRC_EXT1, SRC_AMP2, SRC_FILT, SRC_AMP1, SRC_BATT
    } source_t;
    typedef enum {ST_IDLE, ST_RESET, ST_SAMPLE, ST_CONVERT, ST_STORE} seq_state_t;
endpackage

// ---- src/adc_seq_if.sv ----
// carrier between the bus front and the clock divider
`timescale 1ns/100ps
interface adc_clk_if;
    logic [2:0] div_sel;
    logic       run;
    logic       tick;
    modport ctrl (output div_sel, output run, input tick);
    modport div  (input div_sel, input run, output tick);
endinterface

// ---- src/conv_clock_divider.sv ----
// conversion clock enable divider
`timescale 1ns/100ps
module conv_clock_divider (
    input  wire logic clk,
    input  wire logic resetn,
    adc_clk_if.div    cif
);
    logic [6:0] count;
    logic [6:0] limit;

    assign limit = 7'((8'h01 << cif.div_sel) - 8'h01);

    always_ff @(posedge clk) begin
        if (!resetn || !cif.run) begin
            count    <= 7'h00;
            cif.tick <= 1'b0;
        end else if (count >= limit) begin
            count    <= 7'h00;
            cif.tick <= 1'b1; // R1
        end else begin
            count    <= 7'(count + 7'h01);
            cif.tick <= 1'b0;
        end
    end
endmodule

// ---- src/adc_conversion_sequencer.sv ----
// conversion sequencer with Avalon-MM register slave
`timescale 1ns/100ps
// What this block does
// R1: conversion clock enable is system clock divided by 1 to 128 per select.
// R2: software keeps conversion clock period between 0.5 and 10 us.
// R3: analog power enable follows the power enable bit only.
// R4: software waits settling time after power enable before starting.
// R5: reference select 01 picks regulator output, other codes the pin.
// R6: source codes 001-100 pick internal signals, others the external channel.
// R7: channel 0000 and 0001 connect input zero and one, others float.
// R8: software parks the channel on a missing code before internal source.
// R9: each conversion samples 4 ticks then converts 12, 16 in total.
// R10: a start bit high then low pulse launches the conversion.
// R11: while start is high the converter stays in reset.
// R12: busy flag rises on launch and falls on completion.
// R13: completion sets the request flag and raises irq when enabled.
// R14: accumulate mode runs 16 conversions and stores the 16-bit sum.
// R15: result alignment follows format bit, accumulate is always 16-bit.
// R16: conversion runs in hardware without stalling the processor.
// R17: software enables both interrupt enables before starting.
// R18: analog-selected pins drop pull-up and override port direction.
// R19: software configures divider, enable, source, reference, format, irq, start.
// R20: accumulate clears sum at start and stays busy until the total is stored.
module adc_conversion_sequencer (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [11:0] sar_data,
    output logic             converter_power_enable,
    output logic             converter_reset,
    output logic             sample_hold,
    output logic             sar_tick,
    output logic             use_regulator_ref,
    output logic [6:0]       analog_source_onehot,
    output logic [1:0]       pin_analog_mode,
    output logic             conversion_busy_flag,
    output logic             irq
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]  converter_control_reg_a;
    logic [7:0]  converter_control_reg_b;
    logic        accumulate_mode_bit;
    logic        converter_irq_enable;
    logic        global_irq_enable;
    logic        irq_flag;
    logic [1:0]  port_function_select;
    logic [7:0]  result_high_byte;
    logic [7:0]  result_low_byte;
    logic        bus_ack;
    logic        start_bit;
    logic        start_armed;
    logic        launch;
    logic        done;
    logic        next_busy;
    logic [4:0]  tick_count;
    logic [4:0]  conv_count;
    logic [15:0] accum;
    logic [15:0] sum_next;
    logic [7:0]  next_high;
    logic [7:0]  next_low;
    logic        wr;
    adc_seq_pkg::seq_state_t state;
    adc_clk_if cif ();

    function automatic logic [6:0] source_decode(input logic [2:0] src,
                                                 input logic [3:0] chan);
        logic [6:0] hot;
        hot = 7'h00;
        unique case (src)
            3'h1: hot[adc_seq_pkg::SRC_AMP2] = 1'b1;
            3'h2: hot[adc_seq_pkg::SRC_FILT] = 1'b1;
            3'h3: hot[adc_seq_pkg::SRC_AMP1] = 1'b1;
            3'h4: hot[adc_seq_pkg::SRC_BATT] = 1'b1;
            default: begin
                if (chan == adc_seq_pkg::CHAN_ZERO) begin
                    hot[adc_seq_pkg::SRC_EXT0] = 1'b1;
                end else if (chan == adc_seq_pkg::CHAN_ONE) begin
                    hot[adc_seq_pkg::SRC_EXT1] = 1'b1;
                end else begin
                    hot[adc_seq_pkg::SRC_OFF] = 1'b1;
                end
            end
        endcase
        return hot;
    endfunction

    // writes land on the edge where the master sees waitrequest low
    assign wr = avs_write && bus_ack;
    assign start_bit = converter_control_reg_a[adc_seq_pkg::BIT_START];
    assign cif.div_sel = converter_control_reg_b[adc_seq_pkg::DIV_LSB +: 3];
    assign cif.run = converter_control_reg_a[adc_seq_pkg::BIT_POWER];

    conv_clock_divider u_div (
        .clk    (clk),
        .resetn (resetn),
        .cif    (cif)
    );

    // ************************************************************
    // bus slave: one wait cycle, then ack
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read || avs_write) && !bus_ack;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !bus_ack);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !bus_ack) begin
            unique case (avs_address)
                adc_seq_pkg::ADDR_CTRL_A: avs_readdata <= {24'h00_0000,
                    converter_control_reg_a[7], conversion_busy_flag,
                    converter_control_reg_a[5:0]};
                adc_seq_pkg::ADDR_CTRL_B: avs_readdata <= {24'h00_0000,
                    converter_control_reg_b};
                adc_seq_pkg::ADDR_MODE: avs_readdata <= {26'h000_0000,
                    port_function_select, irq_flag, global_irq_enable,
                    converter_irq_enable, accumulate_mode_bit};
                adc_seq_pkg::ADDR_RES_HIGH: avs_readdata <= {24'h00_0000,
                    result_high_byte};
                adc_seq_pkg::ADDR_RES_LOW: avs_readdata <= {24'h00_0000,
                    result_low_byte};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // busy bit is read-only, the rest of control a is written directly
    always_ff @(posedge clk) begin
        if (!resetn) begin
            converter_control_reg_a <= adc_seq_pkg::CTRL_RESET;
        end else if (wr && avs_address == adc_seq_pkg::ADDR_CTRL_A) begin
            converter_control_reg_a <= {avs_writedata[7], 1'b0, avs_writedata[5:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            converter_control_reg_b <= adc_seq_pkg::CTRL_RESET;
        end else if (wr && avs_address == adc_seq_pkg::ADDR_CTRL_B) begin
            converter_control_reg_b <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            accumulate_mode_bit  <= 1'b0;
            converter_irq_enable <= 1'b0;
            global_irq_enable    <= 1'b0;
            port_function_select <= 2'h0;
        end else if (wr && avs_address == adc_seq_pkg::ADDR_MODE) begin
            accumulate_mode_bit  <= avs_writedata[adc_seq_pkg::BIT_ACCUM];
            converter_irq_enable <= avs_writedata[adc_seq_pkg::BIT_IRQ_EN];
            global_irq_enable    <= avs_writedata[adc_seq_pkg::BIT_GIE];
            port_function_select <= avs_writedata[adc_seq_pkg::BIT_PINSEL1:
                                                  adc_seq_pkg::BIT_PINSEL0];
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_flag <= 1'b0;
        end else if (done) begin
            irq_flag <= 1'b1; // R13
        end else if (wr && avs_address == adc_seq_pkg::ADDR_MODE
                     && !avs_writedata[adc_seq_pkg::BIT_IRQ_FLG]) begin
            irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (irq_flag || done) && converter_irq_enable && global_irq_enable; // R13
        end
    end

    // ************************************************************
    // start pulse detection
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            start_armed <= 1'b0;
        end else begin
            start_armed <= start_bit;
        end
    end
    // a write of start low alone never launches: the high phase must come first
    assign launch = start_armed && !start_bit; // R10

    // ************************************************************
    // sequencer, sample and convert steps run on divider ticks only
    // ************************************************************
    assign done = (state == adc_seq_pkg::ST_STORE);
    assign sum_next = 16'(accum + {4'h0, sar_data}); // R14

    // power off or a held start drops any conversion in flight
    always_ff @(posedge clk) begin
        if (!resetn || !cif.run || start_bit) begin
            state      <= adc_seq_pkg::ST_IDLE; // R11
            tick_count <= 5'h00;
            conv_count <= 5'h00;
            accum      <= 16'h0000;
        end else begin
            unique case (state)
                adc_seq_pkg::ST_IDLE: begin
                    if (launch) begin
                        state      <= adc_seq_pkg::ST_SAMPLE;
                        tick_count <= 5'h00;
                        conv_count <= 5'h00;
                        accum      <= 16'h0000; // R20
                    end
                end
                adc_seq_pkg::ST_RESET: state <= adc_seq_pkg::ST_IDLE;
                adc_seq_pkg::ST_SAMPLE: begin
                    if (cif.tick) begin
                        tick_count <= 5'(tick_count + 5'h01);
                        if (tick_count == adc_seq_pkg::SAMPLE_CYCLES - 5'h01) begin
                            state <= adc_seq_pkg::ST_CONVERT; // R9
                        end
                    end
                end
                adc_seq_pkg::ST_CONVERT: begin
                    if (cif.tick) begin
                        tick_count <= 5'(tick_count + 5'h01);
                        if (tick_count == adc_seq_pkg::TOTAL_CYCLES - 5'h01) begin
                            tick_count <= 5'h00;
                            accum      <= sum_next;
                            conv_count <= 5'(conv_count + 5'h01);
                            if (!accumulate_mode_bit ||
                                conv_count == adc_seq_pkg::ACCUM_COUNT - 5'h01) begin
                                state <= adc_seq_pkg::ST_STORE; // R14
                            end else begin
                                state <= adc_seq_pkg::ST_SAMPLE;
                            end
                        end
                    end
                end
                adc_seq_pkg::ST_STORE: state <= adc_seq_pkg::ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // result registers, kept when powered down
    // ************************************************************
    always_comb begin
        if (accumulate_mode_bit) begin
            next_high = accum[15:8]; // R15
            next_low  = accum[7:0];
        end else if (converter_control_reg_a[adc_seq_pkg::BIT_FORMAT]) begin
            next_high = {4'h0, accum[11:8]};
            next_low  = accum[7:0];
        end else begin
            next_high = accum[11:4];
            next_low  = {accum[3:0], 4'h0};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_high_byte <= 8'h00;
            result_low_byte  <= 8'h00;
        end else if (done) begin
            result_high_byte <= next_high; // R20
            result_low_byte  <= next_low;
        end
    end

    // busy rises with the launch itself, one cycle after start falls, so a poll right after start can still see it low
    assign next_busy = (state == adc_seq_pkg::ST_SAMPLE) ||
                       (state == adc_seq_pkg::ST_CONVERT) ||
                       (state == adc_seq_pkg::ST_IDLE && launch && cif.run);

    // ************************************************************
    // analog-side outputs, all registered
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            conversion_busy_flag <= 1'b0;
        end else begin
            conversion_busy_flag <= next_busy && !start_bit; // R12 R20 R16
        end
    end

    // power off and a held start both keep the converter in reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            converter_power_enable <= 1'b0;
            converter_reset        <= 1'b1;
        end else begin
            converter_power_enable <= cif.run; // R3
            converter_reset        <= start_bit || !cif.run; // R11
        end
    end

    // gated by start so nothing moves while the converter is held in reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sample_hold <= 1'b0;
            sar_tick    <= 1'b0;
        end else begin
            sample_hold <= (state == adc_seq_pkg::ST_SAMPLE) && !start_bit; // R9
            sar_tick    <= cif.tick && (state == adc_seq_pkg::ST_CONVERT) && !start_bit;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            use_regulator_ref    <= 1'b0;
            analog_source_onehot <= 7'h00;
            pin_analog_mode      <= 2'h0;
        end else begin
            use_regulator_ref    <= converter_control_reg_b[adc_seq_pkg::REF_LSB +: 2]
                                    == adc_seq_pkg::REF_INTERNAL; // R5
            analog_source_onehot <= source_decode( // R6 R7
                converter_control_reg_b[adc_seq_pkg::SRC_LSB +: 3],
                converter_control_reg_a[adc_seq_pkg::CHAN_LSB +: 4]);
            pin_analog_mode      <= port_function_select; // R18
        end
    end
endmodule

// ---- tb/afe_model.sv ----
// analog front-end stand-in that feeds the converter result lines
`timescale 1ns/100ps
module afe_model (
    input  wire logic        clk,
    input  wire logic        power,
    input  wire logic        hold,
    input  wire logic [11:0] level,
    output logic      [11:0] sar_data
);
    // ************************************************************
    // result lines
    // ************************************************************
    // unpowered or sampling front end gives no trusted value: lines show the inverse
    always_ff @(posedge clk) begin
        if (power && !hold)
            sar_data <= level;
        else
            sar_data <= ~level;
    end
endmodule

// ---- tb/adc_conversion_sequencer_assertions.sv ----
// port-level assertions for the conversion sequencer
`timescale 1ns/100ps
module seq_checker (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        converter_power_enable,
    input wire logic        converter_reset,
    input wire logic        sample_hold,
    input wire logic        sar_tick,
    input wire logic [6:0]  analog_source_onehot,
    input wire logic        conversion_busy_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ************************************************************
    // conversion ticks since the last sampling phase
    // ************************************************************
    logic [4:0] n_tick;
    always_ff @(posedge clk) begin
        if (!resetn || sample_hold)
            n_tick <= 5'h00;
        else if (sar_tick)
            n_tick <= n_tick + 5'h01;
    end
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait request low for more than one cycle");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:3] !avs_waitrequest) else $error("bus access not answered");
    a_rdata_upper: assert property (avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_source_onehot: assert property ($onehot0(analog_source_onehot))
        else $error("more than one analog source connected");
    a_reset_quiet: assert property (converter_reset && $past(converter_reset)
        |-> !sample_hold && !sar_tick) else $error("converter active while held in reset");
    a_tick_busy: assert property (sar_tick |-> conversion_busy_flag)
        else $error("conversion tick while not busy");
    a_power_reset: assert property (!converter_power_enable |-> converter_reset)
        else $error("converter released while unpowered");
    a_tick_count: assert property ($fell(conversion_busy_flag) && !converter_reset
        |-> n_tick == 5'h0c) else $error("conversion did not take twelve ticks");
endmodule
bind adc_conversion_sequencer seq_checker seq_checker_i (.clk(clk), .resetn(resetn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .converter_power_enable(converter_power_enable),
    .converter_reset(converter_reset), .sample_hold(sample_hold), .sar_tick(sar_tick),
    .analog_source_onehot(analog_source_onehot), .conversion_busy_flag(conversion_busy_flag));

// ---- tb/adc_conversion_sequencer_tb_top.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module adc_conversion_sequencer_tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [11:0] level = 12'h000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, power, conv_rst, hold, tick, reg_ref, busy, irq;
    logic [11:0] sar_data;
    logic [6:0]  src_oh;
    logic [1:0]  pin_mode;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    int          n_fail = 0;
    int          compares = 0;
    int          seed = 32'h5c4d;
    int          n_tick = 0;
    int          n_busy = 0;
    int          n_hold = 0;
    always #10 clk = ~clk;
    adc_conversion_sequencer adc_conversion_sequencer_i (.clk(clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sar_data(sar_data),
        .converter_power_enable(power), .converter_reset(conv_rst), .sample_hold(hold),
        .sar_tick(tick), .use_regulator_ref(reg_ref), .analog_source_onehot(src_oh),
        .pin_analog_mode(pin_mode), .conversion_busy_flag(busy), .irq(irq));
    afe_model afe_model_i (.clk(clk), .power(power), .hold(hold), .level(level),
        .sar_data(sar_data));
    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h00_0000, d};
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({24'h00_0000, e & m});
        mask_q.push_back({24'hff_ffff, m});
        bus(1'b0, a, 8'h00);
    endtask
    // ************************************************************
    // start pulse, then wait for the busy flag to drop
    // ************************************************************
    task automatic convert(input logic [7:0] a_val, input int span, input int convs);
        int t0, b0, h0, nb, nh;
        t0 = n_tick;
        bus(1'b1, adc_seq_pkg::ADDR_CTRL_A, a_val | 8'h80);
        repeat (2) @(posedge clk);
        check("reset while start", conv_rst, 1);
        check("busy while start", busy, 0);
        b0 = n_busy;
        h0 = n_hold;
        bus(1'b1, adc_seq_pkg::ADDR_CTRL_A, a_val);
        repeat (3) @(posedge clk);
        while (busy === 1'b1)
            @(posedge clk);
        nb = n_busy - b0;
        nh = n_hold - h0;
        check("sample span", nh >= (3 * span + 1) * convs && nh <= 4 * span * convs, 1);
        check("ticks", n_tick - t0, 12 * convs);
        check("busy span", nb >= (15 * span + 1) * convs && nb <= (17 * span + 4) * convs, 1);
    endtask
    always @(posedge clk) begin
        n_tick += (tick === 1'b1);
        n_busy += (busy === 1'b1);
        n_hold += (hold === 1'b1);
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            check("read data", avs_readdata & mask_q.pop_front(), exp_q.pop_front());
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        int ch, e;
        repeat (3) @(posedge clk);
        check("wait in reset", avs_waitrequest, 1);
        check("reset when unpowered", conv_rst, 1);
        resetn <= 1'b1;
        rd(adc_seq_pkg::ADDR_CTRL_A, 8'h00, 8'hff);
        rd(adc_seq_pkg::ADDR_CTRL_B, 8'h00, 8'hff);
        rd(adc_seq_pkg::ADDR_MODE, 8'h00, 8'hff);
        bus(1'b1, 4'h7, 8'hff);
        rd(4'h7, 8'h00, 8'hff);
        bus(1'b1, adc_seq_pkg::ADDR_CTRL_A, 8'h40);
        rd(adc_seq_pkg::ADDR_CTRL_A, 8'h00, 8'hff);
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, adc_seq_pkg::ADDR_CTRL_B, 8'(r) << adc_seq_pkg::REF_LSB);
            repeat (2) @(posedge clk);
            check("reference", reg_ref, r == 1);
        end
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, adc_seq_pkg::ADDR_MODE, 8'(p) << adc_seq_pkg::BIT_PINSEL0);
            repeat (2) @(posedge clk);
            check("pin mode", pin_mode, p);
        end
        // settling time after power-up before any start
        bus(1'b1, adc_seq_pkg::ADDR_CTRL_A, 8'h20);
        repeat (40) @(posedge clk);
        check("power", power, 1);
        for (int s = 0; s < 8; s++)
            for (int c = 0; c < 4; c++) begin
                ch = (c < 2) ? c : 13 * c - 24;
                if (s >= 1 && s <= 4 && ch < 2)
                    continue;
                bus(1'b1, adc_seq_pkg::ADDR_CTRL_B, 8'h00);
                bus(1'b1, adc_seq_pkg::ADDR_CTRL_A, 8'h20 | 8'(ch));
                bus(1'b1, adc_seq_pkg::ADDR_CTRL_B, 8'(s) << adc_seq_pkg::SRC_LSB);
                repeat (2) @(posedge clk);
                e = (s >= 1 && s <= 4) ? s + 2 : (ch < 2 ? ch + 1 : 0);
                check("source", src_oh, 1 << e);
            end
        bus(1'b1, adc_seq_pkg::ADDR_CTRL_B, 8'h00);
        // every divider code, alternating the result format
        for (int d = 0; d < 8; d++) begin
            level <= 12'($random(seed));
            bus(1'b1, adc_seq_pkg::ADDR_CTRL_B, 8'(d));
            convert(8'h20 | (8'(d[0]) << adc_seq_pkg::BIT_FORMAT), 1 << d, 1);
            rd(adc_seq_pkg::ADDR_RES_HIGH, d[0] ? {4'h0, level[11:8]} : level[11:4], 8'hff);
            rd(adc_seq_pkg::ADDR_RES_LOW, d[0] ? level[7:0] : {level[3:0], 4'h0},
                d[0] ? 8'hff : 8'hf0);
            rd(adc_seq_pkg::ADDR_MODE, 8'h08, 8'h08);
            check("irq masked", irq, 0);
            bus(1'b1, adc_seq_pkg::ADDR_MODE, 8'h00);
        end
        // accumulate twice: the second total must not include the first
        for (int k = 0; k < 2; k++) begin
            level <= 12'($random(seed));
            bus(1'b1, adc_seq_pkg::ADDR_CTRL_B, 8'h05);
            bus(1'b1, adc_seq_pkg::ADDR_MODE, 8'h07);
            convert(8'h30, 32, 16);
            check("irq raised", irq, 1);
            rd(adc_seq_pkg::ADDR_RES_HIGH, level[11:4], 8'hff);
            rd(adc_seq_pkg::ADDR_RES_LOW, {level[3:0], 4'h0}, 8'hff);
            bus(1'b1, adc_seq_pkg::ADDR_MODE, 8'h07);
            repeat (2) @(posedge clk);
            check("irq cleared", irq, 0);
        end
        bus(1'b1, adc_seq_pkg::ADDR_CTRL_A, 8'h00);
        repeat (2) @(posedge clk);
        check("power off", {power, conv_rst}, 2'b01);
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule
